/* rtl/arcc_ahb_slave.sv */
// AHB-Lite slave: zero-wait writes, one-wait reads with registered read data
`timescale 1ns/1ps
`include "arcc_map.svh"
module arcc_ahb_slave
    import arcc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    arcc_regbus_if.slave     bus
);
    arcc_slave_state_t st_reg;
    arcc_slave_state_t st_next;
    logic              accept;

    always_comb begin
        st_next = st_reg;
        accept  = hsel && htrans[`ARCC_HTRANS_ACT] && hready && (hsize == `ARCC_HSIZE_WORD);
        // Read waits one cycle so the read mux sees any write just completed
        if (st_reg.dataPhase && !st_reg.write && !st_reg.rdDone) begin
            st_next.rdata  = bus.rdData;
            st_next.rdDone = 1'b1;
        end
        if (hready) begin
            st_next.dataPhase = accept;
            st_next.rdDone    = 1'b0;
            if (accept) begin
                st_next.write = hwrite;
                st_next.addr  = haddr[`ARCC_ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.wrEn   = st_reg.dataPhase && st_reg.write;
    assign bus.wrAddr = st_reg.addr;
    assign bus.wrData = hwdata;
    assign bus.rdAddr = st_reg.addr;
    assign hrdata     = st_reg.rdata;
    assign hreadyout  = !(st_reg.dataPhase && !st_reg.write && !st_reg.rdDone);
    assign hresp      = `ARCC_HRESP_OKAY;
endmodule

/* rtl/arcc_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module arcc_sync #(
    parameter int W = 5
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } arcc_sync_state_t;

    arcc_sync_state_t st_reg;
    arcc_sync_state_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.s1   = pinIn;
        st_next.s2   = st_reg.s1;
        st_next.s3   = st_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.filt[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pinOut = st_reg.filt;
endmodule

/* rtl/arcc_top.sv */
// Auxiliary regulator configuration, mode control and status, reached over AHB-Lite
//
// Contract
// - Enable bit in Normal selects stand-alone
// - Load-share bit selects load-sharing configuration
// - First selected configuration is locked
// - Lock survives soft reset, cleared on power
// - Stand-alone: voltage bit picks 5.0V or 3.3V
// - Load-sharing ignores voltage bit, follows main
// - Battery undervoltage switches off, auto re-enables
// - Keep-on bit holds regulator on under undervoltage
// - Load-share with retain bit stays on in Stop
// - Off in Init/Fail-Safe; stand-alone holds otherwise
// - Load-share follows main regulator per mode
// - Status flags readable in supply status register
// - Stop: high-power stage by base current hysteresis
// - Normal: only high-power stage active
// - Change after load-share sets access failure
// - Change after stand-alone silently ignored
// - Stand-alone shunt limit sets sticky overcurrent
// - Stand-alone output undervoltage flag; none sharing
`timescale 1ns/1ps
`include "arcc_map.svh"
module arcc_top
    import arcc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        softRst,
    input  wire logic [2:0]  sbcMode,
    input  wire logic        batteryUnderPin,
    input  wire logic        auxShuntLimitPin,
    input  wire logic        auxOutUnderPin,
    input  wire logic        baseAbovePeakPin,
    input  wire logic        baseBelowPeakPin,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             auxRegOn,
    output logic             auxVoltageLow,
    output logic             auxHighPowerEn,
    output logic             auxLowPowerEn,
    output logic             auxCfgLocked,
    output logic             auxCfgShare
);

    // ****************************************************************
    // Internal signals
    // ****************************************************************
    arcc_regbus_if                   bus ();
    arcc_top_state_t                 st_reg;
    arcc_top_state_t                 st_next;
    logic [`ARCC_PIN_COUNT-1:0]      pinRaw;
    logic [`ARCC_PIN_COUNT-1:0]      pinSync;
    logic                            batUnder;
    logic                            shuntLimit;
    logic                            auxUnder;
    logic                            baseAbove;
    logic                            baseBelow;
    arcc_mode_t                      mode;
    logic                            msWr;
    logic                            hwWr;
    logic                            stWr;
    logic                            failWr;
    logic                            alone;
    logic                            share;
    logic                            want;
    logic [31:0]                     rdWord;

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    assign pinRaw = {baseBelowPeakPin, baseAbovePeakPin, auxOutUnderPin, auxShuntLimitPin, batteryUnderPin};

    arcc_sync #(
        .W (`ARCC_PIN_COUNT)
    ) u_sync (
        .mclk   (mclk),
        .rst    (rst),
        .pinIn  (pinRaw),
        .pinOut (pinSync)
    );

    assign batUnder   = pinSync[0];
    assign shuntLimit = pinSync[1];
    assign auxUnder   = pinSync[2];
    assign baseAbove  = pinSync[3];
    assign baseBelow  = pinSync[4];

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    arcc_ahb_slave u_slave (
        .mclk      (mclk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .bus       (bus.slave)
    );

    // ****************************************************************
    // Write decode
    // ****************************************************************
    assign mode   = arcc_mode_t'(sbcMode);
    assign msWr   = bus.wrEn && (bus.wrAddr == `ARCC_OFS_MSCTRL);
    assign hwWr   = bus.wrEn && (bus.wrAddr == `ARCC_OFS_HWCTRL);
    assign stWr   = bus.wrEn && (bus.wrAddr == `ARCC_OFS_STAT2);
    assign failWr = bus.wrEn && (bus.wrAddr == `ARCC_OFS_FAIL);
    assign alone  = (st_reg.cfg == ARCC_CFG_ALONE);
    assign share  = (st_reg.cfg == ARCC_CFG_SHARE);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        want    = 1'b0;

        // Configuration selection, taken once
        if (st_reg.cfg == ARCC_CFG_NONE) begin
            if (hwWr && bus.wrData[`ARCC_HW_SHARE]) begin
                st_next.cfg = ARCC_CFG_SHARE;
            end else if (msWr && bus.wrData[`ARCC_MS_ENABLE] && (mode == ARCC_MODE_NORMAL)) begin
                st_next.cfg = ARCC_CFG_ALONE;
            end
        end

        // Enable bit: on/off switching stays open in stand-alone, has no function in load-sharing
        if (msWr && !share) begin
            st_next.enable = bus.wrData[`ARCC_MS_ENABLE];
        end
        if (share) begin
            st_next.enable = 1'b0;
        end

        // Remaining control bits stay writable at any time
        if (hwWr) begin
            st_next.retain = bus.wrData[`ARCC_HW_RETAIN];
            st_next.uvKeep = bus.wrData[`ARCC_HW_UVKEEP];
            st_next.vsel   = bus.wrData[`ARCC_HW_VSEL];
        end

        // Access failure: clear first, so a same-cycle attempt wins
        if (failWr && bus.wrData[`ARCC_FAIL_BIT]) begin
            st_next.failFlag = 1'b0;
        end
        if (share && ((hwWr && !bus.wrData[`ARCC_HW_SHARE]) || (msWr && bus.wrData[`ARCC_MS_ENABLE]))) begin
            st_next.failFlag = 1'b1;
        end

        // Sticky status flags, write one to clear, set wins
        if (stWr && bus.wrData[`ARCC_ST_OC]) begin
            st_next.ocFlag = 1'b0;
        end
        if (stWr && bus.wrData[`ARCC_ST_UV]) begin
            st_next.uvFlag = 1'b0;
        end
        if (alone && shuntLimit) begin
            st_next.ocFlag = 1'b1;
        end
        if (alone && auxUnder) begin
            st_next.uvFlag = 1'b1;
        end

        // Regulator request by operating mode
        case (mode)
            ARCC_MODE_NORMAL: begin
                want = (alone && st_reg.enable) || share;
            end
            ARCC_MODE_STOP: begin
                want = (alone && st_reg.modeOn) || (share && st_reg.retain);
            end
            ARCC_MODE_SLEEP: begin
                want = alone && st_reg.modeOn;
            end
            ARCC_MODE_RESTART: begin
                want = (alone && st_reg.modeOn) || share;
            end
            default: begin
                want = 1'b0;
            end
        endcase
        st_next.modeOn = want;

        // Battery undervoltage gating; the request is kept so the output returns by itself
        st_next.regOn = want && !(batUnder && !st_reg.uvKeep);

        // Level select: load-sharing runs at the main regulator's level
        st_next.voltLow = alone && st_reg.vsel;

        // Stage selection with base current hysteresis
        if (baseAbove) begin
            st_next.hpLatch = 1'b1;
        end else if (baseBelow) begin
            st_next.hpLatch = 1'b0;
        end
        if (mode == ARCC_MODE_NORMAL) begin
            st_next.hpEn = st_next.regOn;
            st_next.lpEn = 1'b0;
        end else begin
            st_next.hpEn = st_next.regOn && st_reg.hpLatch;
            st_next.lpEn = st_next.regOn;
        end

        // Soft reset returns control to defaults but keeps the locked configuration
        if (softRst) begin
            st_next     = '0;
            st_next.cfg = st_reg.cfg;
        end
    end

    // ****************************************************************
    // State register; only power-on reset clears the configuration
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        rdWord = `ARCC_ZERO_WORD;
        case (bus.rdAddr)
            `ARCC_OFS_MSCTRL: begin
                rdWord[`ARCC_MS_ENABLE] = st_reg.enable;
            end
            `ARCC_OFS_HWCTRL: begin
                rdWord[`ARCC_HW_SHARE]  = share;
                rdWord[`ARCC_HW_RETAIN] = st_reg.retain;
                rdWord[`ARCC_HW_UVKEEP] = st_reg.uvKeep;
                rdWord[`ARCC_HW_VSEL]   = st_reg.vsel;
            end
            `ARCC_OFS_STAT2: begin
                rdWord[`ARCC_ST_OC]    = st_reg.ocFlag;
                rdWord[`ARCC_ST_UV]    = st_reg.uvFlag;
                rdWord[`ARCC_ST_LOCK]  = (st_reg.cfg != ARCC_CFG_NONE);
                rdWord[`ARCC_ST_SHARE] = share;
                rdWord[`ARCC_ST_ON]    = st_reg.regOn;
                rdWord[`ARCC_ST_HP]    = st_reg.hpEn;
                rdWord[`ARCC_ST_LP]    = st_reg.lpEn;
                rdWord[`ARCC_ST_VLOW]  = st_reg.voltLow;
                rdWord[`ARCC_ST_BATUV] = batUnder;
            end
            `ARCC_OFS_FAIL: begin
                rdWord[`ARCC_FAIL_BIT] = st_reg.failFlag;
            end
            default: begin
                rdWord = `ARCC_ZERO_WORD;
            end
        endcase
    end

    assign bus.rdData = rdWord;

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign auxRegOn       = st_reg.regOn;
    assign auxVoltageLow  = st_reg.voltLow;
    assign auxHighPowerEn = st_reg.hpEn;
    assign auxLowPowerEn  = st_reg.lpEn;
    assign auxCfgLocked   = (st_reg.cfg != ARCC_CFG_NONE);
    assign auxCfgShare    = share;

endmodule

/* shared/arcc_map.svh */
// Register offsets, field positions, reset values and bus codes of the auxiliary regulator control
`ifndef ARCC_MAP_SVH
`define ARCC_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ARCC_OFS_MSCTRL   8'h00
`define ARCC_OFS_HWCTRL   8'h04
`define ARCC_OFS_STAT2    8'h08
`define ARCC_OFS_FAIL     8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define ARCC_MS_ENABLE    0
`define ARCC_HW_SHARE     0
`define ARCC_HW_RETAIN    1
`define ARCC_HW_UVKEEP    2
`define ARCC_HW_VSEL      3
`define ARCC_ST_OC        0
`define ARCC_ST_UV        1
`define ARCC_ST_LOCK      2
`define ARCC_ST_SHARE     3
`define ARCC_ST_ON        4
`define ARCC_ST_HP        5
`define ARCC_ST_LP        6
`define ARCC_ST_VLOW      7
`define ARCC_ST_BATUV     8
`define ARCC_FAIL_BIT     0

// ****************************************************************
// Reset values and bus codes
// ****************************************************************
`define ARCC_ZERO_WORD    32'h0000_0000
`define ARCC_ADDR_W       8
`define ARCC_HTRANS_ACT   1
`define ARCC_HSIZE_WORD   3'h2
`define ARCC_HRESP_OKAY   1'h0
`define ARCC_PIN_COUNT    5

`endif

/* shared/arcc_pkg.sv */
// Types of the auxiliary regulator control block
package arcc_pkg;

    typedef enum logic [2:0] {
        ARCC_MODE_INIT     = 3'b000,
        ARCC_MODE_NORMAL   = 3'b001,
        ARCC_MODE_STOP     = 3'b010,
        ARCC_MODE_SLEEP    = 3'b011,
        ARCC_MODE_RESTART  = 3'b100,
        ARCC_MODE_FAILSAFE = 3'b101
    } arcc_mode_t;

    typedef enum logic [1:0] {
        ARCC_CFG_NONE  = 2'b00,
        ARCC_CFG_ALONE = 2'b01,
        ARCC_CFG_SHARE = 2'b10
    } arcc_cfg_t;

    typedef struct packed {
        arcc_cfg_t cfg;
        logic      enable;
        logic      retain;
        logic      uvKeep;
        logic      vsel;
        logic      ocFlag;
        logic      uvFlag;
        logic      failFlag;
        logic      modeOn;
        logic      hpLatch;
        logic      regOn;
        logic      voltLow;
        logic      hpEn;
        logic      lpEn;
    } arcc_top_state_t;

    typedef struct packed {
        logic        dataPhase;
        logic        write;
        logic        rdDone;
        logic [7:0]  addr;
        logic [31:0] rdata;
    } arcc_slave_state_t;

endpackage

/* shared/arcc_regbus_if.sv */
// Internal register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface arcc_regbus_if;
    logic        wrEn;
    logic [7:0]  wrAddr;
    logic [31:0] wrData;
    logic [7:0]  rdAddr;
    logic [31:0] rdData;

    modport slave (
        output wrEn,
        output wrAddr,
        output wrData,
        output rdAddr,
        input  rdData
    );

    modport regs (
        input  wrEn,
        input  wrAddr,
        input  wrData,
        input  rdAddr,
        output rdData
    );
endinterface

/* testbench/arcc_top_chk.sv */
// Concurrent checks on the auxiliary regulator control ports
`timescale 1ns/1ps
module arcc_top_chk
    import arcc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [2:0] sbcMode,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic [2:0] hsize,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       auxRegOn,
    input wire logic       auxVoltageLow,
    input wire logic       auxHighPowerEn,
    input wire logic       auxLowPowerEn,
    input wire logic       auxCfgLocked,
    input wire logic       auxCfgShare
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_lock_kept: assert property (auxCfgLocked |=> auxCfgLocked)
        else $error("configuration lock dropped");
    chk_share_kept: assert property (auxCfgShare |=> auxCfgShare)
        else $error("shared configuration changed");
    chk_share_locked: assert property (auxCfgShare |-> auxCfgLocked)
        else $error("sharing without lock");
    chk_unlocked_off: assert property (!auxCfgLocked |-> !auxRegOn)
        else $error("regulator on while unconfigured");
    chk_share_vsel: assert property (auxCfgShare |-> !auxVoltageLow)
        else $error("low level selected while sharing");
    chk_init_off: assert property (
        (sbcMode == ARCC_MODE_INIT || sbcMode == ARCC_MODE_FAILSAFE) |=> !auxRegOn)
        else $error("regulator on in init or fail-safe");
    chk_normal_stage: assert property (
        sbcMode == ARCC_MODE_NORMAL |=> auxHighPowerEn == auxRegOn && !auxLowPowerEn)
        else $error("wrong stage in normal mode");
    chk_hp_needs_on: assert property (auxHighPowerEn |-> auxRegOn)
        else $error("high-power stage without regulator");
    chk_read_wait: assert property (
        hsel && htrans[1] && hready && !hwrite && hsize == 3'h2 |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (
        hsel && htrans[1] && hready && hwrite && hsize == 3'h2 |=> hreadyout)
        else $error("write stalled");
endmodule

bind arcc_top arcc_top_chk u_chk (
    .mclk(mclk), .rst(rst), .sbcMode(sbcMode), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .auxRegOn(auxRegOn),
    .auxVoltageLow(auxVoltageLow), .auxHighPowerEn(auxHighPowerEn), .auxLowPowerEn(auxLowPowerEn),
    .auxCfgLocked(auxCfgLocked), .auxCfgShare(auxCfgShare)
);

/* testbench/tb_aux_regulator_config_control.sv */
// Self-checking bench for the auxiliary regulator control block
`timescale 1ns/1ps
`include "arcc_map.svh"
module tb_aux_regulator_config_control
    import arcc_pkg::*;
;
    typedef struct packed {
        arcc_mode_t mode;
        logic [2:0] pins;
        logic [2:0] outs;
    } arcc_row_t;

    logic        mclk             = 1'h0;
    logic        rst              = 1'h1;
    logic        softRst          = 1'h0;
    logic [2:0]  sbcMode          = 3'h0;
    logic        batteryUnderPin  = 1'h0;
    logic        auxShuntLimitPin = 1'h0;
    logic        auxOutUnderPin   = 1'h0;
    logic        baseAbovePeakPin = 1'h0;
    logic        baseBelowPeakPin = 1'h0;
    logic        hsel             = 1'h0;
    logic [31:0] haddr            = 32'h0;
    logic [1:0]  htrans           = 2'h0;
    logic        hwrite           = 1'h0;
    logic [2:0]  hsize            = 3'h2;
    logic [31:0] hwdata           = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        auxRegOn;
    logic        auxVoltageLow;
    logic        auxHighPowerEn;
    logic        auxLowPowerEn;
    logic        auxCfgLocked;
    logic        auxCfgShare;
    logic [31:0] lastRd;
    int          num_errors       = 0;
    int          checks           = 0;

    // Pins are {battery low, base above, base below}; outputs are {on, high-power, low-power}
    arcc_row_t rows [0:21] = '{
        '{ARCC_MODE_NORMAL, 3'h0, 3'h6}, '{ARCC_MODE_STOP, 3'h0, 3'h5}, '{ARCC_MODE_STOP, 3'h2, 3'h7},
        '{ARCC_MODE_STOP, 3'h0, 3'h7}, '{ARCC_MODE_STOP, 3'h1, 3'h5}, '{ARCC_MODE_SLEEP, 3'h0, 3'h5},
        '{ARCC_MODE_RESTART, 3'h0, 3'h5}, '{ARCC_MODE_NORMAL, 3'h4, 3'h0}, '{ARCC_MODE_NORMAL, 3'h0, 3'h6},
        '{ARCC_MODE_INIT, 3'h0, 3'h0}, '{ARCC_MODE_NORMAL, 3'h0, 3'h6}, '{ARCC_MODE_FAILSAFE, 3'h0, 3'h0},
        '{ARCC_MODE_NORMAL, 3'h0, 3'h6}, '{ARCC_MODE_NORMAL, 3'h0, 3'h6}, '{ARCC_MODE_STOP, 3'h0, 3'h0},
        '{ARCC_MODE_SLEEP, 3'h0, 3'h0}, '{ARCC_MODE_RESTART, 3'h0, 3'h5}, '{ARCC_MODE_NORMAL, 3'h4, 3'h0},
        '{ARCC_MODE_INIT, 3'h0, 3'h0}, '{ARCC_MODE_FAILSAFE, 3'h0, 3'h0}, '{ARCC_MODE_NORMAL, 3'h0, 3'h6},
        '{ARCC_MODE_STOP, 3'h0, 3'h5}
    };

    assign hready = hreadyout;

    always #10 mclk = ~mclk;

    arcc_top dut (
        .mclk(mclk), .rst(rst), .softRst(softRst), .sbcMode(sbcMode), .batteryUnderPin(batteryUnderPin),
        .auxShuntLimitPin(auxShuntLimitPin), .auxOutUnderPin(auxOutUnderPin),
        .baseAbovePeakPin(baseAbovePeakPin), .baseBelowPeakPin(baseBelowPeakPin), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .auxRegOn(auxRegOn),
        .auxVoltageLow(auxVoltageLow), .auxHighPowerEn(auxHighPowerEn), .auxLowPowerEn(auxLowPowerEn),
        .auxCfgLocked(auxCfgLocked), .auxCfgShare(auxCfgShare)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] seen, input logic [31:0] expVal);
        checks++;
        if (seen !== expVal) begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, expVal);
        end
    endtask

    // Looks at hready mid-cycle, so the following edge is the one that samples it
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge mclk);
        while (hready !== 1'h1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20) begin
            num_errors++;
            close_out();
        end
        lastRd = hrdata;
        @(posedge mclk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] expVal);
        bus(1'h0, a, 32'h0);
        check_val(lastRd & mask, expVal);
        check_val({31'h0, hresp}, {31'h0, `ARCC_HRESP_OKAY});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    // Outputs as {locked, share, low level, on, high-power, low-power}
    task automatic cfg_check(input logic [5:0] e);
        check_val({26'h0, auxCfgLocked, auxCfgShare, auxVoltageLow, auxRegOn, auxHighPowerEn, auxLowPowerEn},
                  {26'h0, e});
    endtask

    task automatic run_rows(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            @(posedge mclk);
            sbcMode <= rows[i].mode;
            {batteryUnderPin, baseAbovePeakPin, baseBelowPeakPin} <= rows[i].pins;
            settle(8);
            check_val({29'h0, auxRegOn, auxHighPowerEn, auxLowPowerEn}, {29'h0, rows[i].outs});
        end
    endtask

    task automatic pulse_flags();
        @(posedge mclk);
        {auxShuntLimitPin, auxOutUnderPin} <= 2'h3;
        settle(8);
        @(posedge mclk);
        {auxShuntLimitPin, auxOutUnderPin} <= 2'h0;
        settle(8);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        settle(2);
        cfg_check(6'h00);
        rd_check(`ARCC_OFS_STAT2, 32'hFFFF_FFFF, 32'h0);
        bus(1'h1, `ARCC_OFS_MSCTRL, 32'h1);
        settle(2);
        cfg_check(6'h00);
        bus(1'h1, `ARCC_OFS_HWCTRL, 32'h8);
        @(posedge mclk);
        sbcMode <= ARCC_MODE_NORMAL;
        bus(1'h1, `ARCC_OFS_MSCTRL, 32'h1);
        settle(2);
        cfg_check(6'h2E);
        rd_check(`ARCC_OFS_STAT2, 32'hFFFF_FFFF, 32'h0000_00B4);
        bus(1'h1, `ARCC_OFS_HWCTRL, 32'h9);
        settle(2);
        cfg_check(6'h2E);
        rd_check(`ARCC_OFS_FAIL, 32'h1, 32'h0);
        run_rows(0, 12);
        bus(1'h1, `ARCC_OFS_HWCTRL, 32'hC);
        @(posedge mclk);
        batteryUnderPin <= 1'h1;
        settle(8);
        cfg_check(6'h2E);
        @(posedge mclk);
        batteryUnderPin <= 1'h0;
        pulse_flags();
        rd_check(`ARCC_OFS_STAT2, 32'h3, 32'h3);
        bus(1'h1, `ARCC_OFS_STAT2, 32'h3);
        rd_check(`ARCC_OFS_STAT2, 32'h3, 32'h0);
        bus(1'h1, 8'h10, 32'hFFFF_FFFF);
        rd_check(8'h10, 32'hFFFF_FFFF, 32'h0);
        @(posedge mclk);
        softRst <= 1'h1;
        repeat (2) @(posedge mclk);
        softRst <= 1'h0;
        settle(2);
        cfg_check(6'h20);
        @(posedge mclk);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        settle(2);
        cfg_check(6'h00);
        bus(1'h1, `ARCC_OFS_HWCTRL, 32'h9);
        settle(2);
        cfg_check(6'h36);
        rd_check(`ARCC_OFS_HWCTRL, 32'hF, 32'h9);
        run_rows(13, 20);
        bus(1'h1, `ARCC_OFS_MSCTRL, 32'h1);
        settle(2);
        cfg_check(6'h36);
        rd_check(`ARCC_OFS_FAIL, 32'h1, 32'h1);
        bus(1'h1, `ARCC_OFS_HWCTRL, 32'h3);
        run_rows(21, 21);
        pulse_flags();
        rd_check(`ARCC_OFS_STAT2, 32'h3, 32'h0);
        close_out();
    end
endmodule
